// File: src/eight_bit_signaling_channel.sv
// Overview of operation
// - Even slot of a pair is feature control, odd slot is 8-bit signaling.
// - Feature channel handler runs with or without handshake, as selected.
// - Host reads and writes the signaling byte through control memory.
// - Upstream: a confirmed new signaling value raises the interrupt.
// - Upstream: each confirmed change queues its timeslot address in FIFO.
// - Changes are checked by double last-look with programmable period.
// - Upstream: code 1011 on both; even keeps actual, odd keeps stable.
//
// Design decisions made here: the address map and the address-and-strobe port.

module sig_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [PW:0]   count_r;
  wire push = inValid && inReady;
  wire pop  = outValid && outReady;

  assign inReady  = count_r != (PW+1)'(DEPTH);
  assign outValid = count_r != '0;
  assign outData  = mem[rdPtr_r];

  always_ff @(posedge sys_clk) begin
    if (ce && push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (ce) begin
      if (push) wrPtr_r <= wrPtr_r + 1'b1;
      if (pop) rdPtr_r <= rdPtr_r + 1'b1;
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module eight_bit_signaling_channel #(
  parameter int FIFO_W = 8,
  parameter int SLOTS  = 256
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [3:0]       regAddr,
  input  wire logic [7:0]       regWrData,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic [7:0]            regRdData,
  input  wire sig8_pkg::slot_t  rxSlot,
  input  wire logic             dnReq,
  input  wire logic [7:0]       dnAddr,
  output sig8_pkg::slot_t       txSlot,
  output logic                  sigIrq
);
  sig8_pkg::cm_entry_t cm [SLOTS];
  logic [SLOTS-1:0] lookEpoch_r;
  logic [7:0]  data_r;
  logic [7:0]  addr_r;
  logic [3:0]  lastCode_r;
  logic [15:0] period_r;
  logic [15:0] perCnt_r;
  logic        epoch_r;
  logic        handshake_r;
  logic [7:0]  mfTx_r;
  logic [7:0]  mfRx_r;
  logic        mfRxFull_r;
  sig8_pkg::mf_state_t mfState_r;
  sig8_pkg::mf_state_t mfState_nxt;
  logic [7:0]  rdMux;
  logic        fifoInReady;
  logic        fifoOutValid;
  logic [7:0]  fifoOutData;

  // Register decode
  wire wrData   = regWr && regAddr == sig8_pkg::REG_DATA;
  wire wrAddr   = regWr && regAddr == sig8_pkg::REG_ADDR;
  wire wrCmd    = regWr && regAddr == sig8_pkg::REG_CMD;
  wire wrPeriod = regWr && regAddr == sig8_pkg::REG_PERIOD;
  wire wrMfCtl  = regWr && regAddr == sig8_pkg::REG_MFCTL;
  wire wrMfTx   = regWr && regAddr == sig8_pkg::REG_MFTX;
  wire rdFifo   = regRd && regAddr == sig8_pkg::REG_FIFO;
  wire rdMfRx   = regRd && regAddr == sig8_pkg::REG_MFRX;
  wire cmdWrite = wrCmd && regWrData[7:4] == sig8_pkg::CMD_WRITE;
  wire cmdRead  = wrCmd && regWrData[7:4] == sig8_pkg::CMD_READ;
  wire sig8_pkg::cm_entry_t acc = cm[addr_r];

  // Upstream pair lookup
  wire [7:0] rxEvenA = {rxSlot.addr[7:1], 1'b0};
  wire sig8_pkg::cm_entry_t rxEven = cm[rxEvenA];
  wire sig8_pkg::cm_entry_t rxOdd  = cm[rxSlot.addr];
  wire rxUp    = rxSlot.valid && rxSlot.addr[7];
  wire isSigUp = rxEven.code == sig8_pkg::CODE_SIG
              && rxOdd.code == sig8_pkg::CODE_SIG;
  wire rxSigOdd = rxUp && rxSlot.addr[0] && isSigUp;
  wire rxFcEven = rxUp && !rxSlot.addr[0]
               && rxEven.code == sig8_pkg::CODE_SIG;
  wire doLook  = rxSigOdd
              && lookEpoch_r[rxSlot.addr] != epoch_r;
  wire confirm = doLook && rxSlot.data == rxEven.data
              && rxSlot.data != rxOdd.data;
  wire stableWr = confirm && fifoInReady;
  wire periodEnd = perCnt_r >= period_r;

  // Downstream pair lookup
  wire [7:0] dnEvenA = {dnAddr[7:1], 1'b0};
  wire sig8_pkg::cm_entry_t dnEven = cm[dnEvenA];
  wire sig8_pkg::cm_entry_t dnOdd  = cm[dnAddr];
  wire dnDown  = dnReq && !dnAddr[7];
  wire dnSigOdd = dnDown && dnAddr[0]
               && dnOdd.code == sig8_pkg::CODE_SIG
               && dnEven.code == sig8_pkg::CODE_SIGDN;
  wire dnFcEven = dnDown && !dnAddr[0]
               && dnEven.code == sig8_pkg::CODE_SIGDN;
  wire mfSend = !handshake_r || mfState_r == sig8_pkg::MF_PEND;
  wire [7:0] fcByte = mfSend ? mfTx_r : sig8_pkg::IDLE_BYTE;
  wire [7:0] txByte = dnSigOdd ? dnEven.data : fcByte;
  wire mfRxTake = rxFcEven && (!handshake_r || !mfRxFull_r);

  always_comb begin
    mfState_nxt = mfState_r;
    unique case (mfState_r)
      sig8_pkg::MF_IDLE: begin
        if (wrMfTx) mfState_nxt = sig8_pkg::MF_PEND;
      end
      sig8_pkg::MF_PEND: begin
        if (dnFcEven) mfState_nxt = sig8_pkg::MF_IDLE;
      end
    endcase
  end

  assign rdMux =
      regAddr == sig8_pkg::REG_DATA  ? data_r :
      regAddr == sig8_pkg::REG_ADDR  ? addr_r :
      regAddr == sig8_pkg::REG_CMD   ? {4'h0, lastCode_r} :
      regAddr == sig8_pkg::REG_PERIOD ? period_r[7:0] :
      regAddr == sig8_pkg::REG_FIFO  ? fifoOutData :
      regAddr == sig8_pkg::REG_MFCTL ? {7'h00, handshake_r} :
      regAddr == sig8_pkg::REG_MFTX  ? mfTx_r :
      regAddr == sig8_pkg::REG_MFRX  ? mfRx_r :
      regAddr == sig8_pkg::REG_STAT  ?
        {5'h00, mfState_r == sig8_pkg::MF_PEND, mfRxFull_r,
         fifoOutValid} : 8'h00;

  sig_fifo #(
    .W     (FIFO_W),
    .DEPTH (sig8_pkg::FIFO_DEPTH)
  ) changeFifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .ce       (ce),
    .inValid  (confirm),
    .inReady  (fifoInReady),
    .inData   (rxSlot.addr),
    .outValid (fifoOutValid),
    .outReady (rdFifo),
    .outData  (fifoOutData)
  );

  // Control memory: host access wins over line updates
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SLOTS; i++) begin
        cm[i] <= '{code: sig8_pkg::CODE_RST, data: sig8_pkg::BYTE_RST};
      end
    end else if (ce) begin
      if (doLook) cm[rxEvenA].data <= rxSlot.data;
      if (stableWr) cm[rxSlot.addr].data <= rxSlot.data;
      if (cmdWrite) begin
        cm[addr_r] <= '{code: regWrData[3:0], data: data_r};
      end
    end
  end

  // Last-look epoch per slot
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lookEpoch_r <= '0;
    end else if (ce && doLook && (fifoInReady || !confirm)) begin
      lookEpoch_r[rxSlot.addr] <= epoch_r;
    end
  end

  // Programmable look period
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      perCnt_r <= '0;
      epoch_r  <= 1'b0;
    end else if (ce) begin
      perCnt_r <= periodEnd ? '0 : perCnt_r + 16'h0001;
      if (periodEnd) epoch_r <= !epoch_r;
    end
  end

  // Indirect access triple
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_r     <= sig8_pkg::BYTE_RST;
      addr_r     <= sig8_pkg::BYTE_RST;
      lastCode_r <= sig8_pkg::CODE_RST;
    end else if (ce) begin
      if (wrData) data_r <= regWrData;
      if (wrAddr) addr_r <= regWrData;
      if (cmdRead) begin
        data_r     <= acc.data;
        lastCode_r <= acc.code;
      end
    end
  end

  // Look period, low byte writable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      period_r <= sig8_pkg::PERIOD_RST;
    end else if (ce && wrPeriod) begin
      period_r <= {8'h00, regWrData};
    end
  end

  // Feature channel protocol select
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      handshake_r <= 1'b0;
    end else if (ce && wrMfCtl) begin
      handshake_r <= regWrData[0];
    end
  end

  // Feature channel transmit byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mfTx_r <= sig8_pkg::IDLE_BYTE;
    end else if (ce && wrMfTx) begin
      mfTx_r <= regWrData;
    end
  end

  // Feature channel transmit state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mfState_r <= sig8_pkg::MF_IDLE;
    end else if (ce) begin
      mfState_r <= mfState_nxt;
    end
  end

  // Feature channel receive byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mfRx_r <= sig8_pkg::IDLE_BYTE;
    end else if (ce && mfRxTake) begin
      mfRx_r <= rxSlot.data;
    end
  end

  // Receive full flag; a new byte beats the read clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mfRxFull_r <= 1'b0;
    end else if (ce) begin
      if (mfRxTake) begin
        mfRxFull_r <= 1'b1;
      end else if (rdMfRx) begin
        mfRxFull_r <= 1'b0;
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdData <= sig8_pkg::BYTE_RST;
    end else if (ce) begin
      regRdData <= rdMux;
    end
  end

  // Downstream slot answer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txSlot <= '0;
    end else if (ce) begin
      txSlot <= '{valid: dnSigOdd || dnFcEven, addr: dnAddr,
                  data: txByte};
    end
  end

  // Change interrupt level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sigIrq <= 1'b0;
    end else if (ce) begin
      sigIrq <= fifoOutValid || stableWr;
    end
  end
endmodule

// File: src/sig8_pkg.sv
package sig8_pkg;
  localparam int AW = 8;
  localparam int DW = 8;
  // Register offsets
  localparam logic [3:0] REG_DATA   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_CMD    = 4'h2;
  localparam logic [3:0] REG_PERIOD = 4'h3;
  localparam logic [3:0] REG_FIFO   = 4'h4;
  localparam logic [3:0] REG_MFCTL  = 4'h5;
  localparam logic [3:0] REG_MFTX   = 4'h6;
  localparam logic [3:0] REG_MFRX   = 4'h7;
  localparam logic [3:0] REG_STAT   = 4'h8;
  // Command nibbles and control memory codes
  localparam logic [3:0] CMD_WRITE  = 4'h7;
  localparam logic [3:0] CMD_READ   = 4'he;
  localparam logic [3:0] CODE_SIGDN = 4'ha;
  localparam logic [3:0] CODE_SIG   = 4'hb;
  localparam logic [3:0] CODE_RST   = 4'h0;
  // Reset values and FIFO depth
  localparam logic [15:0] PERIOD_RST = 16'h00ff;
  localparam logic [7:0]  IDLE_BYTE  = 8'hff;
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [3:0] code;
    logic [7:0] data;
  } cm_entry_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } slot_t;

  typedef enum logic [0:0] {
    MF_IDLE = 1'b0,
    MF_PEND = 1'b1
  } mf_state_t;
endpackage

// File: verification/sig8_chk_sva.sv
module sig8_chk (
  input wire logic            sys_clk,
  input wire logic            rst,
  input wire logic [3:0]      regAddr,
  input wire logic            regRd,
  input wire logic [7:0]      regRdData,
  input wire sig8_pkg::slot_t rxSlot,
  input wire logic            dnReq,
  input wire logic [7:0]      dnAddr,
  input wire sig8_pkg::slot_t txSlot,
  input wire logic            sigIrq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire fifoRd = regRd && regAddr == sig8_pkg::REG_FIFO;
  wire oddUp  = rxSlot.valid && rxSlot.addr[7] && rxSlot.addr[0];
  chk_up_refused: assert property (
    dnReq && dnAddr[7] |=> !txSlot.valid) else $error("up slot served");
  chk_tx_addr: assert property (
    dnReq |=> txSlot.addr == $past(dnAddr)) else $error("tx addr wrong");
  chk_tx_cause: assert property (
    $rose(txSlot.valid) |-> $past(dnReq)) else $error("tx without req");
  chk_irq_cause: assert property (
    $rose(sigIrq) |-> $past(oddUp)) else $error("irq without slot");
  chk_irq_hold: assert property (
    $fell(sigIrq) |-> $past(fifoRd) || $past(fifoRd, 2))
    else $error("irq dropped early");
  chk_fifo_addr: assert property (
    fifoRd && sigIrq && !$past(regRd) |=> regRdData[7] && regRdData[0])
    else $error("fifo head not odd up");
  chk_unmapped_zero: assert property (
    regRd && regAddr > sig8_pkg::REG_STAT |=> regRdData == 8'h00)
    else $error("unmapped read not 0");
  chk_irq_release: assert property (
    $fell(rst) |-> !sigIrq) else $error("irq after reset");
  cover property ($rose(sigIrq));
  cover property (fifoRd && sigIrq);
  cover property (dnReq && !dnAddr[7] ##1 txSlot.valid);
endmodule

bind eight_bit_signaling_channel sig8_chk chk_u (
  .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regRd(regRd),
  .regRdData(regRdData), .rxSlot(rxSlot), .dnReq(dnReq),
  .dnAddr(dnAddr), .txSlot(txSlot), .sigIrq(sigIrq));

// File: verification/codec_model.sv
module codec_model (
  input  wire logic       sys_clk,
  input  wire logic       en,
  input  wire logic [7:0] upAddr,
  input  wire logic [7:0] sigVal,
  input  wire logic [7:0] featVal,
  output sig8_pkg::slot_t rxSlot
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt = 2'h0;
  logic       odd = 1'b0;
  initial rxSlot = '0;
  // Even feature slot, then odd signaling slot, every third cycle
  always @(posedge sys_clk) begin
    cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
    rxSlot.valid <= en && cnt == 2'h2;
    if (en && cnt == 2'h2) begin
      odd <= ~odd;
      rxSlot.addr <= {upAddr[7:1], odd};
      rxSlot.data <= odd ? sigVal : featVal;
    end else
      rxSlot.data <= ~rxSlot.data;
  end
endmodule

// File: verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic            sys_clk   = 1'b0;
  logic            rst       = 1'b1;
  logic            ce        = 1'b1;
  logic [3:0]      regAddr   = 4'h0;
  logic [7:0]      regWrData = 8'h00;
  logic            regWr     = 1'b0;
  logic            regRd     = 1'b0;
  logic            dnReq     = 1'b0;
  logic [7:0]      dnAddr    = 8'h00;
  logic            en        = 1'b0;
  logic [7:0]      sigVal    = 8'h00;
  logic [7:0]      featVal   = 8'h00;
  logic [7:0]      regRdData;
  logic            sigIrq;
  logic [7:0]      d;
  sig8_pkg::slot_t rxSlot;
  sig8_pkg::slot_t txSlot;
  int              miscompares = 0;
  int              num_checks  = 0;
  always #5 sys_clk = ~sys_clk;
  eight_bit_signaling_channel dut_u (.sys_clk(sys_clk), .rst(rst),
    .ce(ce), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .rxSlot(rxSlot), .dnReq(dnReq),
    .dnAddr(dnAddr), .txSlot(txSlot), .sigIrq(sigIrq));
  codec_model model_u (.sys_clk(sys_clk), .en(en), .upAddr(8'hb0),
    .sigVal(sigVal), .featVal(featVal), .rxSlot(rxSlot));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic put(input logic [7:0] a, c, v);
    wr(sig8_pkg::REG_DATA, v);
    wr(sig8_pkg::REG_ADDR, a);
    wr(sig8_pkg::REG_CMD, {sig8_pkg::CMD_WRITE, c[3:0]});
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] v);
    wr(sig8_pkg::REG_ADDR, a);
    wr(sig8_pkg::REG_CMD, {sig8_pkg::CMD_READ, sig8_pkg::CODE_RST});
    rd(sig8_pkg::REG_DATA, v);
  endtask
  task automatic dn(input logic [7:0] a);
    @(posedge sys_clk);
    dnReq <= 1'b1;
    dnAddr <= a;
    @(posedge sys_clk);
    dnReq <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    rd(sig8_pkg::REG_PERIOD, d);
    chk(d, 8'hff);
    rd(4'hf, d);
    chk(d, 8'h00);
    rd(sig8_pkg::REG_MFRX, d);
    chk(d, 8'hff);
    chk({7'h0, sigIrq}, 8'h00);
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(sig8_pkg::REG_MFTX, 8'h12);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd(sig8_pkg::REG_MFTX, d);
    chk(d, 8'hff);
  endtask
  task automatic t_down;
    put(8'h10, {4'h0, sig8_pkg::CODE_SIGDN}, 8'h45);
    put(8'h11, {4'h0, sig8_pkg::CODE_SIG}, 8'h00);
    dn(8'h11);
    chk({7'h0, txSlot.valid}, 8'h01);
    chk(txSlot.data, 8'h45);
    dn(8'h10);
    chk(txSlot.data, 8'hff);
    wr(sig8_pkg::REG_MFTX, 8'h3c);
    dn(8'h10);
    chk(txSlot.data, 8'h3c);
    put(8'h90, {4'h0, sig8_pkg::CODE_SIGDN}, 8'h45);
    put(8'h91, {4'h0, sig8_pkg::CODE_SIG}, 8'h00);
    dn(8'h91);
    chk({7'h0, txSlot.valid}, 8'h00);
    get(8'h10, d);
    chk(d, 8'h45);
    rd(sig8_pkg::REG_CMD, d);
    chk({4'h0, d[3:0]}, {4'h0, sig8_pkg::CODE_SIGDN});
    wr(sig8_pkg::REG_MFCTL, 8'h01);
    dn(8'h10);
    chk(txSlot.data, 8'hff);
    wr(sig8_pkg::REG_MFTX, 8'h99);
    rd(sig8_pkg::REG_STAT, d);
    chk(d, 8'h04);
    dn(8'h10);
    chk(txSlot.data, 8'h99);
    dn(8'h10);
    chk(txSlot.data, 8'hff);
  endtask
  task automatic t_up;
    int i;
    wr(sig8_pkg::REG_MFCTL, 8'h00);
    wr(sig8_pkg::REG_PERIOD, 8'h04);
    put(8'hb0, {4'h0, sig8_pkg::CODE_SIG}, 8'h00);
    put(8'hb1, {4'h0, sig8_pkg::CODE_SIG}, 8'hd6);
    sigVal <= 8'hd6;
    featVal <= 8'h77;
    en <= 1'b1;
    repeat (40) @(posedge sys_clk);
    #1 chk({7'h0, sigIrq}, 8'h00);
    rd(sig8_pkg::REG_MFRX, d);
    chk(d, 8'h77);
    sigVal <= 8'h5a;
    for (i = 0; i < 100 && sigIrq !== 1'b1; i++) @(negedge sys_clk);
    #1 chk({7'h0, sigIrq}, 8'h01);
    get(8'hb0, d);
    chk(d, 8'h5a);
    get(8'hb1, d);
    chk(d, 8'h5a);
    rd(sig8_pkg::REG_FIFO, d);
    chk(d, 8'hb1);
    repeat (2) @(posedge sys_clk);
    #1 chk({7'h0, sigIrq}, 8'h00);
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_down;
    t_up;
    wrap_up;
  end
  initial begin
    #30000;
    miscompares++;
    wrap_up;
  end
endmodule
